// ===== sim/rccd_core_asserts.sv
`timescale 1ns/1ps
module rccd_core_asserts import rccd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Watched ports
  input wire rccd_bus_req_t busReq,
  input wire logic [15:0] busRdata,
  input wire logic busAck,
  input wire logic [15:0] statusReg
);
  logic req;
  assign req = busReq.rd || busReq.wr;
  default clocking dc @(posedge clock); endclocking
  default disable iff (reset);
  a_reset_quiet: assert property (disable iff (1'b0) reset |=> !req)
    else $error("bus request during reset");
  a_status_clear: assert property (disable iff (1'b0) reset |=> statusReg == 16'h0000)
    else $error("status word not cleared by reset");
  a_vector_fetch: assert property ($fell(reset) |-> ##[0:2] (busReq.rd && busReq.addr == 16'hFFFE))
    else $error("no reset vector read after release");
  a_req_stable: assert property (req && !busAck |=> $stable(busReq))
    else $error("request changed before acknowledge");
  a_drop_after: assert property (req && busAck |=> !req)
    else $error("request not released after acknowledge");
  a_single_access: assert property (!(busReq.rd && busReq.wr))
    else $error("read and write at once");
  a_word_even: assert property (req && !busReq.byteAccess |-> busReq.addr[0] == 1'b0)
    else $error("word access at odd address");
  a_next_soon: assert property (req && busAck |-> ##[2:6] req)
    else $error("core stalled after an access");
endmodule

bind rccd_core rccd_core_asserts i_rccd_core_asserts (.clock(clock), .reset(reset), .busReq(busReq),
  .busRdata(busRdata), .busAck(busAck), .statusReg(statusReg));

// ===== sim/rccd_mem_model.sv
`timescale 1ns/1ps
module rccd_mem_model import rccd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Core side
  input wire rccd_bus_req_t busReq,
  output logic [15:0] busRdata,
  output logic busAck,
  // Answer delay in cycles
  input wire logic [1:0] waitCyc
);
  logic [15:0] mem [0:32767];
  logic [15:0] word;
  logic [15:0] last_ff;
  logic [1:0] cnt_ff;
  // Peripherals would sit in this one space and answer the same cycles.
  assign word = mem[busReq.addr[15:1]];
  assign busAck = (busReq.rd || busReq.wr) && cnt_ff == waitCyc && !reset;
  // Outside an answer the lines show the inverse of the last word, so a late sample is caught.
  assign busRdata = (busAck && busReq.rd) ? (busReq.addr[0] ? {word[7:0], word[15:8]} : word) : ~last_ff;
  initial begin
    for (int i = 0; i < 32768; i++) mem[i] = 16'h0000;
    last_ff = 16'h0000;
  end
  always_ff @(posedge clock) begin
    if (reset || !(busReq.rd || busReq.wr) || busAck) cnt_ff <= 2'h0;
    else cnt_ff <= cnt_ff + 2'h1;
  end
  always @(posedge clock) begin
    if (busAck) begin
      last_ff <= busReq.wr ? busReq.wdata : busRdata;
      if (busReq.wr && !busReq.byteAccess) mem[busReq.addr[15:1]] <= busReq.wdata;
      if (busReq.wr && busReq.byteAccess && busReq.addr[0]) mem[busReq.addr[15:1]][15:8] <= busReq.wdata[7:0];
      if (busReq.wr && busReq.byteAccess && !busReq.addr[0]) mem[busReq.addr[15:1]][7:0] <= busReq.wdata[7:0];
    end
  end
endmodule

// ===== sim/tb.sv
`timescale 1ns/1ps
module tb import rccd_pkg::*;;
  logic clock = 1'b0;
  logic reset = 1'b1;
  logic [1:0] waitCyc = 2'h0;
  rccd_bus_req_t busReq;
  logic [15:0] busRdata;
  logic [15:0] statusReg;
  logic busAck;
  int err_total = 0;
  int tests_run = 0;
  int cyc = 0;
  logic [15:0] wA[$];
  logic [15:0] wD[$];
  logic wB[$];
  int ackCyc[logic [15:0]];

  always #50 clock = ~clock;

  rccd_core i_rccd_core (.clock(clock), .reset(reset), .busReq(busReq), .busRdata(busRdata),
    .busAck(busAck), .statusReg(statusReg));
  rccd_mem_model i_rccd_mem_model (.clock(clock), .reset(reset), .busReq(busReq), .busRdata(busRdata),
    .busAck(busAck), .waitCyc(waitCyc));

  // The whole run needs well under 1000 cycles; the ceiling leaves ample margin.
  always @(posedge clock) begin
    cyc <= cyc + 1;
    if (busAck && busReq.wr) begin
      wA.push_back(busReq.addr);
      wD.push_back(busReq.wdata);
      wB.push_back(busReq.byteAccess);
    end
    if (busAck && busReq.rd) ackCyc[busReq.addr] = cyc;
    if (cyc == 20000) begin
      err_total++;
      give_verdict();
    end
  end

  task automatic give_verdict();
    $display("errors %0d checks %0d", err_total, tests_run);
    if (err_total == 0 && tests_run > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic boot(input logic [15:0] p[$], input int n, input logic [1:0] w);
    @(posedge clock);
    reset <= 1'b1;
    waitCyc <= w;
    foreach (p[i]) i_rccd_mem_model.mem[16'h0800 + i] = p[i];
    i_rccd_mem_model.mem[16'h7FFF] = 16'h1000;
    repeat (10) @(posedge clock);
    wA.delete();
    wD.delete();
    wB.delete();
    ackCyc.delete();
    reset <= 1'b0;
    repeat (400) if (wA.size() < n) @(posedge clock);
    @(negedge clock);
    check(16'(wA.size()), 16'(n));
  endtask

  task automatic t_reg_timing(input logic [1:0] w);
    boot('{16'h4034, 16'h1234, 16'h440F, 16'h4F82, 16'h0200}, 1, w);
    check(16'(ackCyc.exists(16'hFFFE)), 16'h0001);
    check(wA[0], 16'h0200);
    check(wD[0], 16'h1234);
    check(16'(ackCyc[16'h1006] - ackCyc[16'h1004]), 16'h0003 + w);
  endtask

  task automatic t_add_flags();
    boot('{16'h4034, 16'h0007, 16'h4035, 16'hFFF9, 16'h5405, 16'h4582, 16'h0202}, 1, 2'h1);
    check(wD[0], 16'h0000);
    check(statusReg & 16'h0107, 16'h0003);
  endtask

  task automatic t_byte();
    boot('{16'h4034, 16'h12AB, 16'h44C2, 16'h0205, 16'h4446, 16'h4682, 16'h0206, 16'h4257, 16'h0205,
      16'h4782, 16'h0208}, 3, 2'h0);
    check(wA[0], 16'h0205);
    check(16'(wB[0]), 16'h0001);
    check(wD[0] & 16'h00FF, 16'h00AB);
    check(wD[1], 16'h00AB);
    check(wD[2], 16'h00AB);
  endtask

  task automatic t_autoinc();
    i_rccd_mem_model.mem[16'h0180] = 16'h1111;
    i_rccd_mem_model.mem[16'h0181] = 16'h2222;
    boot('{16'h403A, 16'h0300, 16'h4A3B, 16'h4A7C, 16'h4A82, 16'h0208, 16'h4B82, 16'h020A, 16'h4C82,
      16'h020C}, 3, 2'h2);
    check(wD[0], 16'h0303);
    check(wD[1], 16'h1111);
    check(wD[2], 16'h0022);
  endtask

  task automatic t_offsets();
    i_rccd_mem_model.mem[16'h0180] = 16'h1111;
    i_rccd_mem_model.mem[16'h0181] = 16'h2222;
    i_rccd_mem_model.mem[16'h0182] = 16'h3333;
    boot('{16'h4035, 16'h0300, 16'h4516, 16'h0002, 16'h4217, 16'h0300, 16'h4018, 16'hF2F6, 16'h4682,
      16'h0210, 16'h4782, 16'h0212, 16'h4882, 16'h0214, 16'h4685, 16'h0004, 16'h4595, 16'h0002,
      16'h0006}, 5, 2'h0);
    check(wD[0], 16'h2222);
    check(wD[1], 16'h1111);
    check(wD[2], 16'h3333);
    check(wA[3], 16'h0304);
    check(wD[3], 16'h2222);
    check(wA[4], 16'h0306);
    check(wD[4], 16'h2222);
  endtask

  task automatic t_alu();
    // Results are parked in memory so the flags after the subtract and the end of the chain can be checked write by write.
    boot('{16'h4031, 16'h0400, 16'h4034, 16'h1234, 16'h4035, 16'h00F0, 16'h8405, 16'h4282, 16'h0230,
      16'hE405, 16'h1085, 16'h1185, 16'h1105, 16'hC405, 16'hD315, 16'h4582, 16'h0232, 16'h9505, 16'h2401,
      16'h4504, 16'h1230, 16'h1040, 16'h1204, 16'h1300, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
      16'h0000, 16'h0000, 16'h0000, 16'h4282, 16'h0238}, 5, 2'h0);
    check(wD[0], 16'h0004);
    check(wD[1], 16'hEDCB);
    check(wA[2], 16'h03FE);
    check(wD[2], 16'h1040);
    check(wD[3], 16'h1234);
    check(wD[4], 16'h1234);
    check(statusReg, 16'h1234);
  endtask

  task automatic t_call_jump();
    logic [15:0] q[$] = '{16'h3C02, 16'h4882, 16'h0220, 16'h4314, 16'h4335, 16'h4503, 16'h4482, 16'h0222,
      16'h4582, 16'h0224, 16'h4382, 16'h0226};
    // The routine sits apart from the entry code, so only a taken call can reach it.
    foreach (q[i]) i_rccd_mem_model.mem[16'h0880 + i] = q[i];
    boot('{16'h4031, 16'h0400, 16'h4038, 16'h1100, 16'h1288}, 4, 2'h1);
    check(wA[0], 16'h03FE);
    check(wD[0], 16'h100A);
    check(wA[1], 16'h0222);
    check(wD[1], 16'h0001);
    check(wD[2], 16'hFFFF);
    check(wD[3], 16'h0000);
  endtask

  initial begin
    t_reg_timing(2'h0);
    t_reg_timing(2'h2);
    t_add_flags();
    t_byte();
    t_autoinc();
    t_offsets();
    t_call_jump();
    t_alu();
    give_verdict();
  end
endmodule

// ===== verilog/rccd_core.sv
`timescale 1ns/1ps
module rccd_core import rccd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Shared memory and peripheral bus
  output rccd_bus_req_t busReq,
  input wire logic [15:0] busRdata,
  input wire logic busAck,
  // Status word
  output logic [15:0] statusReg
);

  rccd_state_t state_ff;
  rccd_state_t nxt_state;
  logic [15:0] ir_ff;
  logic [15:0] srcVal_ff;
  logic [15:0] dstVal_ff;
  logic [15:0] srcAddr_ff;
  logic [15:0] dstAddr_ff;
  logic [15:0] res_ff;
  logic [15:0] sr_ff;
  logic busPend_ff;
  rccd_bus_req_t busReq_ff;
  rccd_bus_req_t reqNow;

  rccd_instr_t dec;
  logic [15:0] rdA;
  logic [15:0] rdB;
  logic [15:0] pcVal;
  logic [15:0] spVal;
  logic wEnLo;
  logic [3:0] wIdxLo;
  logic [15:0] wDatLo;
  logic wEnHi;
  logic [3:0] wIdxHi;
  logic [15:0] wDatHi;

  logic done;
  logic isCg;
  logic [15:0] cgVal;
  logic [15:0] regSrc;
  logic [15:0] regDst;
  logic [15:0] srcImm;
  logic directExec;
  logic doExec;
  logic memDest;
  logic [3:0] targetIdx;
  logic [15:0] mask;
  logic [15:0] rdMasked;
  logic [15:0] stackTopLocation;
  logic jumpTaken;

  logic [15:0] opS;
  logic [15:0] opD;
  logic [15:0] aluRes;
  logic fC;
  logic fV;
  logic flagsUpd;
  logic resWrites;
  logic isStackOp;

  assign dec = rccd_decode(ir_ff);
  assign done = busPend_ff && busAck;
  assign mask = dec.byteOp ? 16'h00FF : 16'hFFFF;
  assign rdMasked = busRdata & mask;
  assign stackTopLocation = spVal - WORD_STEP;
  assign busReq = busReq_ff;
  assign statusReg = sr_ff;

  rccd_regfile u_regs (
    .clock(clock),
    .reset(reset),
    .rdIdxA(dec.srcIdx),
    .rdDataA(rdA),
    .rdIdxB(dec.dstIdx),
    .rdDataB(rdB),
    .pcVal(pcVal),
    .spVal(spVal),
    .wrEnLo(wEnLo),
    .wrIdxLo(wIdxLo),
    .wrDataLo(wDatLo),
    .wrEnHi(wEnHi),
    .wrIdxHi(wIdxHi),
    .wrDataHi(wDatHi)
  );

  // Operand selection: the status word and the two constant sources are not in the register file.
  always_comb begin
    isCg = (dec.srcIdx == REG_CONST_SOURCE_SECOND) || (dec.srcIdx == REG_SR && dec.srcMode[1]);
    unique case ({dec.srcIdx == REG_SR, dec.srcMode})
      3'b1_10: cgVal = 16'h0004;
      3'b1_11: cgVal = 16'h0008;
      3'b0_00: cgVal = 16'h0000;
      3'b0_01: cgVal = 16'h0001;
      3'b0_10: cgVal = 16'h0002;
      default: cgVal = 16'hFFFF;
    endcase
    regSrc = (dec.srcIdx == REG_PC) ? pcVal : (dec.srcIdx == REG_SR) ? sr_ff : rdA;
    regDst = (dec.dstIdx == REG_PC) ? pcVal : (dec.dstIdx == REG_SR) ? sr_ff : rdB;
    srcImm = isCg ? cgVal : regSrc;
    isStackOp = dec.fmt == FMT_SINGLE && (dec.op == OP_PUSH || dec.op == OP_CALL);
    directExec = (dec.fmt == FMT_DUAL || dec.fmt == FMT_SINGLE) && dec.op != OP_RETI
                 && (isCg || dec.srcMode == AM_REGISTER) && !dec.dstMode;
    doExec = (state_ff == ST_DECODE && directExec) || state_ff == ST_EXEC;
    memDest = (dec.fmt == FMT_DUAL) ? dec.dstMode : (dec.srcMode != AM_REGISTER && !isCg);
    targetIdx = (dec.fmt == FMT_DUAL) ? dec.dstIdx : dec.srcIdx;
    unique case (dec.cond)
      3'h0: jumpTaken = !sr_ff[SR_Z];
      3'h1: jumpTaken = sr_ff[SR_Z];
      3'h2: jumpTaken = !sr_ff[SR_C];
      3'h3: jumpTaken = sr_ff[SR_C];
      3'h4: jumpTaken = sr_ff[SR_N];
      3'h5: jumpTaken = sr_ff[SR_N] == sr_ff[SR_V];
      3'h6: jumpTaken = sr_ff[SR_N] != sr_ff[SR_V];
      default: jumpTaken = 1'b1;
    endcase
  end

  // Arithmetic and logic on word or byte width.
  always_comb begin
    logic [15:0] s;
    logic [15:0] d;
    logic [15:0] addB;
    logic cin;
    logic [16:0] sum;
    logic [16:0] bcd;
    logic [15:0] raw;
    logic msbS;
    logic msbD;
    s = 16'h0000;
    d = 16'h0000;
    addB = 16'h0000;
    cin = 1'b0;
    sum = 17'h00000;
    bcd = 17'h00000;
    raw = 16'h0000;
    msbS = 1'b0;
    msbD = 1'b0;
    opS = (state_ff == ST_DECODE) ? srcImm : srcVal_ff;
    opD = dec.dstMode ? dstVal_ff : regDst;
    s = opS & mask;
    d = opD & mask;
    fC = sr_ff[SR_C];
    fV = 1'b0;
    flagsUpd = 1'b1;
    resWrites = 1'b1;
    addB = (dec.op == OP_SUB || dec.op == OP_SUBC || dec.op == OP_CMP) ? (~s & mask) : s;
    cin = (dec.op == OP_SUB || dec.op == OP_CMP) ? 1'b1 : (dec.op == OP_ADD) ? 1'b0 : sr_ff[SR_C];
    sum = {1'b0, d} + {1'b0, addB} + {16'h0000, cin};
    bcd = rccd_dadd(d, s, sr_ff[SR_C]);
    msbS = dec.byteOp ? addB[7] : addB[15];
    msbD = dec.byteOp ? d[7] : d[15];
    if (dec.fmt == FMT_DUAL) begin
      case (dec.op)
        OP_MOV: begin
          raw = s;
          flagsUpd = 1'b0;
        end
        OP_ADD, OP_ADDC, OP_SUB, OP_SUBC, OP_CMP: begin
          raw = sum[15:0];
          fC = dec.byteOp ? sum[8] : sum[16];
          fV = (msbS == msbD) && ((dec.byteOp ? sum[7] : sum[15]) != msbD);
          resWrites = dec.op != OP_CMP;
        end
        OP_DADD: begin
          raw = bcd[15:0];
          fC = dec.byteOp ? bcd[8] : bcd[16];
        end
        OP_BIT, OP_AND: begin
          raw = d & s;
          fC = (raw & mask) != 16'h0000;
          resWrites = dec.op == OP_AND;
        end
        OP_BIC: begin
          raw = d & ~s;
          flagsUpd = 1'b0;
        end
        OP_BIS: begin
          raw = d | s;
          flagsUpd = 1'b0;
        end
        default: begin
          raw = d ^ s;
          fC = (raw & mask) != 16'h0000;
          fV = (dec.byteOp ? s[7] & d[7] : s[15] & d[15]);
        end
      endcase
    end else begin
      case (dec.op)
        OP_RRC, OP_RRA: begin
          raw = {1'b0, s[15:1]};
          if (dec.byteOp) begin
            raw[7] = (dec.op == OP_RRC) ? sr_ff[SR_C] : s[7];
          end else begin
            raw[15] = (dec.op == OP_RRC) ? sr_ff[SR_C] : s[15];
          end
          fC = s[0];
        end
        OP_SWPB: begin
          raw = {s[7:0], s[15:8]};
          flagsUpd = 1'b0;
        end
        OP_SXT: begin
          raw = {{8{s[7]}}, s[7:0]};
          fC = raw != 16'h0000;
        end
        default: begin
          resWrites = 1'b0;
          flagsUpd = 1'b0;
        end
      endcase
    end
    aluRes = raw & mask;
  end

  // Sequencing and register writes; the high write port carries results, the low one pointer steps.
  always_comb begin
    nxt_state = state_ff;
    wEnLo = 1'b0;
    wIdxLo = REG_PC;
    wDatLo = pcVal + WORD_STEP;
    wEnHi = 1'b0;
    wIdxHi = REG_PC;
    wDatHi = aluRes;
    unique case (state_ff)
      ST_VECT: begin
        if (done) begin
          wEnHi = 1'b1;
          wDatHi = busRdata;
          nxt_state = ST_FETCH;
        end
      end
      ST_FETCH: begin
        if (done) begin
          wEnLo = 1'b1;
          nxt_state = ST_DECODE;
        end
      end
      ST_DECODE: begin
        if (dec.fmt == FMT_BAD) begin
          nxt_state = ST_FETCH;
        end else if (dec.fmt == FMT_JUMP) begin
          wEnHi = jumpTaken;
          wDatHi = pcVal + {{5{dec.offs[9]}}, dec.offs, 1'b0};
          nxt_state = ST_FETCH;
        end else if (dec.fmt == FMT_SINGLE && dec.op == OP_RETI) begin
          nxt_state = ST_POPSR;
        end else if (!isCg && dec.srcMode == AM_INDEXED) begin
          nxt_state = ST_SRCX;
        end else if (!isCg && dec.srcMode[1]) begin
          wEnLo = dec.srcMode == AM_AUTOINC;
          wIdxLo = dec.srcIdx;
          wDatLo = regSrc + ((dec.byteOp && dec.srcIdx > REG_SP) ? BYTE_STEP : WORD_STEP);
          nxt_state = ST_SRCM;
        end else if (dec.dstMode) begin
          nxt_state = ST_DSTX;
        end
      end
      ST_SRCX, ST_DSTX: begin
        if (done) begin
          wEnLo = 1'b1;
          // An indexed source is read before any destination offset is fetched, so memory to memory works.
          nxt_state = (state_ff == ST_DSTX) ? ((dec.op == OP_MOV) ? ST_EXEC : ST_DSTM) : ST_SRCM;
        end
      end
      ST_SRCM: begin
        if (done) begin
          nxt_state = (dec.fmt == FMT_DUAL && dec.dstMode) ? ST_DSTX : ST_EXEC;
        end
      end
      ST_DSTM: begin
        if (done) begin
          nxt_state = ST_EXEC;
        end
      end
      ST_STORE: begin
        if (done) begin
          nxt_state = ST_FETCH;
        end
      end
      ST_PUSH: begin
        if (done) begin
          wEnLo = 1'b1;
          wIdxLo = REG_SP;
          wDatLo = stackTopLocation;
          wEnHi = dec.op == OP_CALL;
          wDatHi = srcVal_ff;
          nxt_state = ST_FETCH;
        end
      end
      ST_POPSR, ST_POPPC: begin
        if (done) begin
          wEnLo = 1'b1;
          wIdxLo = REG_SP;
          wDatLo = spVal + WORD_STEP;
          wEnHi = state_ff == ST_POPPC;
          wDatHi = busRdata;
          nxt_state = (state_ff == ST_POPSR) ? ST_POPPC : ST_FETCH;
        end
      end
      default: begin
      end
    endcase
    if (doExec) begin
      if (isStackOp) begin
        nxt_state = ST_PUSH;
      end else if (resWrites && memDest) begin
        nxt_state = ST_STORE;
      end else begin
        wEnHi = resWrites && targetIdx != REG_SR;
        wIdxHi = targetIdx;
        wDatHi = aluRes;
        nxt_state = ST_FETCH;
      end
    end
  end

  // Bus request for the current state; every access goes over the one shared bus.
  always_comb begin
    reqNow = '0;
    reqNow.byteAccess = dec.byteOp;
    unique case (state_ff)
      ST_VECT: begin
        reqNow.rd = 1'b1;
        reqNow.addr = RESET_VECTOR;
        reqNow.byteAccess = 1'b0;
      end
      ST_FETCH, ST_SRCX, ST_DSTX: begin
        reqNow.rd = 1'b1;
        reqNow.addr = pcVal;
        reqNow.byteAccess = 1'b0;
      end
      ST_SRCM, ST_DSTM: begin
        reqNow.rd = 1'b1;
        reqNow.addr = (state_ff == ST_SRCM) ? srcAddr_ff : dstAddr_ff;
      end
      ST_STORE: begin
        reqNow.wr = 1'b1;
        reqNow.addr = dstAddr_ff;
        reqNow.wdata = res_ff;
      end
      ST_PUSH: begin
        reqNow.wr = 1'b1;
        reqNow.addr = stackTopLocation;
        reqNow.wdata = (dec.op == OP_CALL) ? pcVal : srcVal_ff;
        reqNow.byteAccess = 1'b0;
      end
      ST_POPSR, ST_POPPC: begin
        reqNow.rd = 1'b1;
        reqNow.addr = spVal;
        reqNow.byteAccess = 1'b0;
      end
      default: begin
      end
    endcase
  end

  // A request is raised one cycle after entering a bus state and held until acknowledged.
  always_ff @(posedge clock) begin
    if (reset) begin
      busPend_ff <= 1'b0;
      busReq_ff <= '0;
    end else if (done) begin
      busPend_ff <= 1'b0;
      busReq_ff <= '0;
    end else if (!busPend_ff && (reqNow.rd || reqNow.wr)) begin
      busPend_ff <= 1'b1;
      busReq_ff <= reqNow;
    end
  end

  always_ff @(posedge clock) begin
    if (reset) begin
      state_ff <= ST_VECT;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // Operand, address and result latches.
  always_ff @(posedge clock) begin
    if (reset) begin
      ir_ff <= 16'h0000;
      srcVal_ff <= 16'h0000;
      dstVal_ff <= 16'h0000;
      srcAddr_ff <= 16'h0000;
      dstAddr_ff <= 16'h0000;
      res_ff <= 16'h0000;
    end else begin
      if (state_ff == ST_FETCH && done) begin
        ir_ff <= busRdata;
      end
      if (state_ff == ST_DECODE) begin
        srcVal_ff <= srcImm & mask;
        srcAddr_ff <= regSrc;
        dstAddr_ff <= regSrc;
      end
      if (state_ff == ST_SRCX && done) begin
        srcAddr_ff <= busRdata + ((dec.srcIdx == REG_SR) ? 16'h0000 : regSrc);
        dstAddr_ff <= busRdata + ((dec.srcIdx == REG_SR) ? 16'h0000 : regSrc);
      end
      if (state_ff == ST_SRCM && done) begin
        srcVal_ff <= rdMasked;
      end
      if (state_ff == ST_DSTX && done) begin
        dstAddr_ff <= busRdata + ((dec.dstIdx == REG_SR) ? 16'h0000 : regDst);
      end
      if (state_ff == ST_DSTM && done) begin
        dstVal_ff <= rdMasked;
      end
      if (doExec) begin
        res_ff <= aluRes;
      end
    end
  end

  // Status word: a result aimed at it wins over the flag update of the same operation.
  always_ff @(posedge clock) begin
    if (reset) begin
      sr_ff <= 16'h0000;
    end else if (state_ff == ST_POPSR && done) begin
      sr_ff <= busRdata;
    end else if (doExec && !isStackOp) begin
      if (resWrites && !memDest && targetIdx == REG_SR) begin
        sr_ff <= aluRes;
      end else if (flagsUpd) begin
        sr_ff[SR_C] <= fC;
        sr_ff[SR_Z] <= aluRes == 16'h0000;
        sr_ff[SR_N] <= dec.byteOp ? aluRes[7] : aluRes[15];
        sr_ff[SR_V] <= fV;
      end
    end
  end

endmodule

// ===== verilog/rccd_pkg.sv
package rccd_pkg;

  localparam logic [15:0] RESET_VECTOR = 16'hFFFE;
  localparam logic [15:0] WORD_STEP = 16'h0002;
  localparam logic [15:0] BYTE_STEP = 16'h0001;

  localparam logic [3:0] REG_PC = 4'h0;
  localparam logic [3:0] REG_SP = 4'h1;
  localparam logic [3:0] REG_SR = 4'h2;
  localparam logic [3:0] REG_CONST_SOURCE_SECOND = 4'h3;

  localparam int SR_C = 0;
  localparam int SR_Z = 1;
  localparam int SR_N = 2;
  localparam int SR_V = 8;

  // Source addressing codes.
  localparam logic [1:0] AM_REGISTER = 2'h0;
  localparam logic [1:0] AM_INDEXED = 2'h1;
  localparam logic [1:0] AM_INDIRECT = 2'h2;
  localparam logic [1:0] AM_AUTOINC = 2'h3;

  // Dual-operand opcodes.
  localparam logic [3:0] OP_MOV = 4'h4;
  localparam logic [3:0] OP_ADD = 4'h5;
  localparam logic [3:0] OP_ADDC = 4'h6;
  localparam logic [3:0] OP_SUBC = 4'h7;
  localparam logic [3:0] OP_SUB = 4'h8;
  localparam logic [3:0] OP_CMP = 4'h9;
  localparam logic [3:0] OP_DADD = 4'hA;
  localparam logic [3:0] OP_BIT = 4'hB;
  localparam logic [3:0] OP_BIC = 4'hC;
  localparam logic [3:0] OP_BIS = 4'hD;
  localparam logic [3:0] OP_XOR = 4'hE;
  localparam logic [3:0] OP_AND = 4'hF;

  // Single-operand opcodes.
  localparam logic [3:0] OP_RRC = 4'h0;
  localparam logic [3:0] OP_SWPB = 4'h1;
  localparam logic [3:0] OP_RRA = 4'h2;
  localparam logic [3:0] OP_SXT = 4'h3;
  localparam logic [3:0] OP_PUSH = 4'h4;
  localparam logic [3:0] OP_CALL = 4'h5;
  localparam logic [3:0] OP_RETI = 4'h6;

  typedef enum logic [1:0] {
    FMT_DUAL = 2'h0,
    FMT_SINGLE = 2'h1,
    FMT_JUMP = 2'h2,
    FMT_BAD = 2'h3
  } rccd_fmt_t;

  typedef enum logic [3:0] {
    ST_VECT = 4'h0,
    ST_FETCH = 4'h1,
    ST_DECODE = 4'h2,
    ST_SRCX = 4'h3,
    ST_SRCM = 4'h4,
    ST_DSTX = 4'h5,
    ST_DSTM = 4'h6,
    ST_EXEC = 4'h7,
    ST_STORE = 4'h8,
    ST_PUSH = 4'h9,
    ST_POPSR = 4'hA,
    ST_POPPC = 4'hB
  } rccd_state_t;

  typedef struct packed {
    rccd_fmt_t fmt;
    logic [3:0] op;
    logic [3:0] srcIdx;
    logic [1:0] srcMode;
    logic dstMode;
    logic byteOp;
    logic [3:0] dstIdx;
    logic [2:0] cond;
    logic [9:0] offs;
  } rccd_instr_t;

  typedef struct packed {
    logic rd;
    logic wr;
    logic byteAccess;
    logic [15:0] addr;
    logic [15:0] wdata;
  } rccd_bus_req_t;

  function automatic rccd_instr_t rccd_decode(input logic [15:0] ir);
    rccd_instr_t d;
    d.op = ir[15:12];
    d.srcIdx = ir[11:8];
    d.srcMode = ir[5:4];
    d.dstMode = ir[7];
    d.byteOp = ir[6];
    d.dstIdx = ir[3:0];
    d.cond = ir[12:10];
    d.offs = ir[9:0];
    d.fmt = FMT_BAD;
    if (ir[15:14] != 2'h0) begin
      d.fmt = FMT_DUAL;
    end else if (ir[15:13] == 3'h1) begin
      d.fmt = FMT_JUMP;
    end else if (ir[15:10] == 6'h04 && ir[9:7] != 3'h7) begin
      d.fmt = FMT_SINGLE;
      d.op = {1'b0, ir[9:7]};
      d.srcIdx = ir[3:0];
      d.dstMode = 1'b0;
      if (ir[9:7] == 3'h1 || ir[9:7] >= 3'h5) begin
        d.byteOp = 1'b0;
      end
    end
    return d;
  endfunction

  function automatic logic [16:0] rccd_dadd(input logic [15:0] a, input logic [15:0] b, input logic cin);
    logic [4:0] nib;
    logic c;
    logic [15:0] r;
    c = cin;
    r = 16'h0000;
    for (int i = 0; i < 4; i++) begin
      nib = {1'b0, a[i*4+:4]} + {1'b0, b[i*4+:4]} + {4'h0, c};
      if (nib > 5'h09) begin
        nib = nib + 5'h06;
        c = 1'b1;
      end else begin
        c = 1'b0;
      end
      r[i*4+:4] = nib[3:0];
    end
    return {c, r};
  endfunction

endpackage

// ===== verilog/rccd_regfile.sv
`timescale 1ns/1ps
module rccd_regfile import rccd_pkg::*; (
  // Clock and reset
  input wire logic clock,
  input wire logic reset,
  // Read ports
  input wire logic [3:0] rdIdxA,
  output logic [15:0] rdDataA,
  input wire logic [3:0] rdIdxB,
  output logic [15:0] rdDataB,
  output logic [15:0] pcVal,
  output logic [15:0] spVal,
  // Write ports, the high one wins on the same index
  input wire logic wrEnLo,
  input wire logic [3:0] wrIdxLo,
  input wire logic [15:0] wrDataLo,
  input wire logic wrEnHi,
  input wire logic [3:0] wrIdxHi,
  input wire logic [15:0] wrDataHi
);

  logic [15:0] regs_ff [16];

  // Slots two and three hold nothing: the status word lives in the core and slot three is the constant source.
  genvar g;
  generate
    for (g = 0; g < 16; g++) begin : gen_reg
      if (g == 2 || g == 3) begin : gen_none
        always_comb begin
          regs_ff[g] = 16'h0000;
        end
      end else begin : gen_store
        always_ff @(posedge clock) begin
          if (reset) begin
            regs_ff[g] <= 16'h0000;
          end else if (wrEnHi && wrIdxHi == 4'(g)) begin
            regs_ff[g] <= wrDataHi;
          end else if (wrEnLo && wrIdxLo == 4'(g)) begin
            regs_ff[g] <= wrDataLo;
          end
        end
      end
    end
  endgenerate

  assign rdDataA = regs_ff[rdIdxA];
  assign rdDataB = regs_ff[rdIdxB];
  assign pcVal = regs_ff[REG_PC];
  assign spVal = regs_ff[REG_SP];

endmodule
